// file: hw/aaie_exec.sv
`timescale 1ns/1ps
`include "aaie_map.svh"
// Notes on behaviour
// - A read-modify-write of the port register uses the synchronised pin levels.
// - Loading direction latches with operand 6 copies the accumulator into them.
// - A one in a direction latch turns that pin's output driver off.
// - A file op writing back to the timer register clears the prescaler if assigned.
// - The add-to-file op sums accumulator and file and updates carry, half-carry, zero.
// - Destination bit 0 sends the result to the accumulator, 1 back to the file.
// - The AND-with-file op ands accumulator and file and updates only zero.
// - The AND-literal op ands the accumulator with the literal into the accumulator.
// - The low five bits address the file and bit 5 is the destination select.
module aaie_exec
  import aaie_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Instruction stream
  input wire logic instr_valid,
  input wire logic [11:0] instr_word,
  // Timer side
  input wire logic prescaler_on_timer,
  output logic prescaler_clear,
  // Port pins
  input wire logic [WIDTH-1:0] gpio_pin_in,
  output logic [WIDTH-1:0] gpio_pin_out,
  output logic [WIDTH-1:0] gpio_pin_oe,
  // Core state
  output logic [WIDTH-1:0] acc,
  output aaie_flags_t flags,
  output logic exec_done,
  output logic instr_unsupported,
  // File observation port
  input wire logic [4:0] file_rd_addr,
  output logic [WIDTH-1:0] file_rd_data
);

  logic [WIDTH-1:0] acc_reg;
  aaie_flags_t flags_reg;
  logic [WIDTH-1:0] oe_reg;
  logic [WIDTH-1:0] latch_reg;
  logic [WIDTH-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
  logic [WIDTH-1:0] file_mem [DEPTH];
  logic prescaler_clear_reg, exec_done_reg, unsup_reg;
  logic [WIDTH-1:0] file_rd_data_reg;

  aaie_dec_t dec;
  logic [WIDTH-1:0] operand, result;
  logic [8:0] sum9;
  logic [4:0] sum_low;
  logic wr_file, wr_acc;

  // One decoder for the whole word; unknown patterns fall to none
  function automatic aaie_dec_t decode(input logic [11:0] w);
    aaie_dec_t d;
    d.op = AAIE_OP_NONE;
    d.dest_file = w[`AAIE_DEST_BIT];
    d.addr = w[`AAIE_ADDR_MSB:0];
    d.lit = w[`AAIE_LIT_MSB:0];
    if (w[11:6] == `AAIE_OPC_ADD_FILE) begin
      d.op = AAIE_OP_ADD_FILE;
    end else if (w[11:6] == `AAIE_OPC_AND_FILE) begin
      d.op = AAIE_OP_AND_FILE;
    end else if (w[11:8] == `AAIE_OPC_AND_LIT) begin
      d.op = AAIE_OP_AND_LIT;
    end else if (w[11:3] == `AAIE_OPC_LOAD_DIR && w[2:0] != 3'h0) begin
      d.op = AAIE_OP_LOAD_DIR;
    end
    return d;
  endfunction

  assign dec = decode(instr_word);

  // Port reads come from the pins, not the latch, so driven-low inputs write back zero
  assign operand = (dec.addr == `AAIE_GPIO_ADDR) ? pin_reg : file_mem[dec.addr];
  assign sum9 = {1'b0, acc_reg} + {1'b0, operand};
  assign sum_low = {1'b0, acc_reg[3:0]} + {1'b0, operand[3:0]};

  // Result select and destination steering
  always_comb begin
    result = acc_reg;
    wr_file = 1'b0;
    wr_acc = 1'b0;
    if (instr_valid) begin
      unique case (dec.op)
        AAIE_OP_ADD_FILE: begin
          result = sum9[7:0];
          wr_file = dec.dest_file;
          wr_acc = !dec.dest_file;
        end
        AAIE_OP_AND_FILE: begin
          result = acc_reg & operand;
          wr_file = dec.dest_file;
          wr_acc = !dec.dest_file;
        end
        AAIE_OP_AND_LIT: begin
          result = acc_reg & dec.lit;
          wr_acc = 1'b1;
        end
        AAIE_OP_LOAD_DIR, AAIE_OP_NONE: begin
          result = acc_reg;
        end
      endcase
    end
  end

  // Pin synchroniser; a bit moves only once stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
      pin_reg <= '0;
    end else begin
      pin_s1_reg <= gpio_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  // Accumulator, single cycle per op
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_reg <= `AAIE_ACC_RST;
    end else if (wr_acc) begin
      acc_reg <= result;
    end
  end

  // Status flags; the AND ops leave carry and half-carry alone
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= '0;
    end else if (instr_valid && dec.op == AAIE_OP_ADD_FILE) begin
      flags_reg.carry <= sum9[8];
      flags_reg.half_carry <= sum_low[4];
      flags_reg.zero <= (sum9[7:0] == '0);
    end else if (instr_valid && (dec.op == AAIE_OP_AND_FILE || dec.op == AAIE_OP_AND_LIT)) begin
      flags_reg.zero <= (result == '0);
    end
  end

  // File write-back; the port address lands in the output latch instead
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latch_reg <= `AAIE_LATCH_RST;
      for (int i = 0; i < DEPTH; i++) begin
        file_mem[i] <= `AAIE_FILE_RST;
      end
    end else if (wr_file) begin
      if (dec.addr == `AAIE_GPIO_ADDR) begin
        latch_reg <= result;
      end else begin
        file_mem[dec.addr] <= result;
      end
    end
  end

  // Direction latches kept as drive enables, so the pin enable leaves a flop directly
  // Reset leaves every pin as input so nothing fights an outside driver
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oe_reg <= ~`AAIE_DIR_RST;
    end else if (instr_valid && dec.op == AAIE_OP_LOAD_DIR
                 && dec.addr[2:0] == `AAIE_DIR_PORT) begin
      oe_reg <= ~acc_reg;
    end
  end

  // Prescaler clear pulse; only when the result really goes back to the timer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prescaler_clear_reg <= 1'b0;
    end else begin
      prescaler_clear_reg <= wr_file && dec.addr == `AAIE_TIMER_ADDR
                             && prescaler_on_timer;
    end
  end

  // Completion and unsupported-word pulses, plus the observation port
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      exec_done_reg <= 1'b0;
      unsup_reg <= 1'b0;
      file_rd_data_reg <= '0;
    end else begin
      exec_done_reg <= instr_valid && dec.op != AAIE_OP_NONE;
      unsup_reg <= instr_valid && dec.op == AAIE_OP_NONE;
      file_rd_data_reg <= (file_rd_addr == `AAIE_GPIO_ADDR) ? pin_reg : file_mem[file_rd_addr];
    end
  end

  assign acc = acc_reg;
  assign flags = flags_reg;
  assign gpio_pin_out = latch_reg;
  assign gpio_pin_oe = oe_reg;
  assign prescaler_clear = prescaler_clear_reg;
  assign exec_done = exec_done_reg;
  assign instr_unsupported = unsup_reg;
  assign file_rd_data = file_rd_data_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic is_add, is_andf, is_andl, is_dir6;
  assign is_add = instr_valid && dec.op == AAIE_OP_ADD_FILE;
  assign is_andf = instr_valid && dec.op == AAIE_OP_AND_FILE;
  assign is_andl = instr_valid && dec.op == AAIE_OP_AND_LIT;
  assign is_dir6 = instr_valid && dec.op == AAIE_OP_LOAD_DIR && dec.addr[2:0] == `AAIE_DIR_PORT;

  // Rule-side view of a timer write-back while the prescaler belongs to the timer
  logic presc_hit;
  assign presc_hit = (is_add || is_andf) && dec.dest_file && dec.addr == `AAIE_TIMER_ADDR
                     && prescaler_on_timer;

  property p_add_acc;
    is_add && !dec.dest_file |=> acc_reg == $past(sum9[7:0]);
  endproperty
  a_add_acc: assert property (p_add_acc) else $error("add result wrong");

  property p_add_flags;
    is_add |=> flags_reg.carry == $past(sum9[8]) && flags_reg.half_carry == $past(sum_low[4]);
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add carry flags wrong");

  property p_zero;
    (is_add || is_andf || is_andl) |=> flags_reg.zero == ($past(result) == '0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_and_keeps_carry;
    (is_andf || is_andl) |=> $stable(flags_reg.carry) && $stable(flags_reg.half_carry);
  endproperty
  a_and_keeps_carry: assert property (p_and_keeps_carry) else $error("carry moved");

  property p_andl;
    is_andl |=> acc_reg == ($past(acc_reg) & $past(dec.lit));
  endproperty
  a_andl: assert property (p_andl) else $error("and literal wrong");

  property p_dest_file;
    (is_add || is_andf) && dec.dest_file |=> $stable(acc_reg);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("acc changed on file dest");

  property p_port_rmw;
    is_andf && !dec.dest_file && dec.addr == `AAIE_GPIO_ADDR
      |=> acc_reg == ($past(acc_reg) & $past(pin_reg));
  endproperty
  a_port_rmw: assert property (p_port_rmw) else $error("port read not from pins");

  property p_dir_load;
    is_dir6 |=> gpio_pin_oe == ~$past(acc_reg) ##1 ($past(is_dir6) || $stable(gpio_pin_oe));
  endproperty
  a_dir_load: assert property (p_dir_load) else $error("dir load wrong");

  property p_presc;
    presc_hit |=> prescaler_clear_reg;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler clear wrong");

  property p_presc_only;
    prescaler_clear_reg |-> $past(presc_hit);
  endproperty
  a_presc_only: assert property (p_presc_only) else $error("stray prescaler clear");

  // The pulse may only stay up when another instruction follows at once
  property p_done;
    (is_add || is_andf || is_andl) |=> exec_done_reg ##1 ($past(instr_valid) || !exec_done_reg);
  endproperty
  a_done: assert property (p_done) else $error("op not done in one cycle");

  c_add_carry: cover property (is_add ##1 flags_reg.carry);
  c_port_rmw: cover property (is_andf && dec.addr == `AAIE_GPIO_ADDR && dec.dest_file);
  c_presc: cover property (prescaler_clear_reg);
  c_dir_load: cover property (is_dir6 ##1 gpio_pin_oe != '0);

endmodule

// file: hw/aaie_map.svh
`ifndef AAIE_MAP_SVH
`define AAIE_MAP_SVH

// Opcode fields, compared against instruction bits [11:6] or [11:8] or [11:3]
`define AAIE_OPC_ADD_FILE 6'h07
`define AAIE_OPC_AND_FILE 6'h05
`define AAIE_OPC_AND_LIT 4'hE
`define AAIE_OPC_LOAD_DIR 9'h000

// Field positions inside the 12-bit word
`define AAIE_DEST_BIT 5
`define AAIE_ADDR_MSB 4
`define AAIE_LIT_MSB 7

// File addresses with side effects
`define AAIE_TIMER_ADDR 5'h01
`define AAIE_GPIO_ADDR 5'h06
`define AAIE_DIR_PORT 3'h6

// Reset values
`define AAIE_ACC_RST 8'h00
`define AAIE_FILE_RST 8'h00
`define AAIE_DIR_RST 8'hFF
`define AAIE_LATCH_RST 8'h00

`endif

// file: hw/aaie_pkg.sv
package aaie_pkg;

  typedef enum logic [2:0] {
    AAIE_OP_NONE,
    AAIE_OP_ADD_FILE,
    AAIE_OP_AND_FILE,
    AAIE_OP_AND_LIT,
    AAIE_OP_LOAD_DIR
  } aaie_op_t;

  typedef struct packed {
    logic carry;
    logic half_carry;
    logic zero;
  } aaie_flags_t;

  typedef struct packed {
    aaie_op_t op;
    logic dest_file;
    logic [4:0] addr;
    logic [7:0] lit;
  } aaie_dec_t;

endpackage

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import aaie_pkg::*;
;
  logic sys_clk;
  logic rst;
  logic instr_valid;
  logic [11:0] instr_word;
  logic prescaler_on_timer;
  logic prescaler_clear;
  logic [7:0] gpio_pin_in;
  logic [7:0] gpio_pin_out;
  logic [7:0] gpio_pin_oe;
  logic [7:0] acc;
  aaie_flags_t flags;
  logic exec_done;
  logic instr_unsupported;
  logic [4:0] file_rd_addr;
  logic [7:0] file_rd_data;
  int fails = 0;
  int samples_checked = 0;

  aaie_exec #(.WIDTH(8), .DEPTH(32)) aaie_exec_inst (
    .sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .prescaler_on_timer(prescaler_on_timer), .prescaler_clear(prescaler_clear),
    .gpio_pin_in(gpio_pin_in), .gpio_pin_out(gpio_pin_out), .gpio_pin_oe(gpio_pin_oe),
    .acc(acc), .flags(flags), .exec_done(exec_done), .instr_unsupported(instr_unsupported),
    .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data)
  );

  // Clock at 40 MHz
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flags(input aaie_flags_t got, input logic [2:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One instruction, then the one-cycle pulses and the fall of exec_done a cycle later
  task automatic op(input logic [11:0] w, input logic ed, input logic eu, input logic ep);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    cmp_bit(exec_done, ed);
    cmp_bit(instr_unsupported, eu);
    cmp_bit(prescaler_clear, ep);
    @(posedge sys_clk);
    #1;
    cmp_bit(exec_done, 1'b0);
  endtask

  task automatic core(input logic [7:0] a, input logic [2:0] f);
    cmp_byte(acc, a);
    cmp_flags(flags, f);
  endtask

  // Pins pass a synchroniser, so hold them well past its latency
  task automatic set_pins(input logic [7:0] v);
    @(posedge sys_clk);
    gpio_pin_in <= v;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic rd_file(input logic [4:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    file_rd_addr <= a;
    @(posedge sys_clk);
    #1;
    cmp_byte(file_rd_data, exp);
  endtask

  // Reset state, then an unknown word that must leave everything alone
  task automatic test_idle();
    core(8'h00, 3'b000);
    cmp_byte(gpio_pin_oe, 8'h00);
    op(12'h000, 1'b0, 1'b1, 1'b0);
    core(8'h00, 3'b000);
  endtask

  // Add from the port and from a file cell, both destinations, each flag both set and clear
  task automatic test_add_and();
    set_pins(8'hC2);
    op(12'h1C6, 1'b1, 1'b0, 1'b0);
    core(8'hC2, 3'b000);
    op(12'h1E2, 1'b1, 1'b0, 1'b0);
    core(8'hC2, 3'b000);
    rd_file(5'h02, 8'hC2);
    op(12'hE00, 1'b1, 1'b0, 1'b0);
    core(8'h00, 3'b001);
    set_pins(8'h17);
    op(12'h1C6, 1'b1, 1'b0, 1'b0);
    op(12'h1C2, 1'b1, 1'b0, 1'b0);
    core(8'hD9, 3'b000);
    rd_file(5'h02, 8'hC2);
    op(12'h1E2, 1'b1, 1'b0, 1'b0);
    core(8'hD9, 3'b100);
    rd_file(5'h02, 8'h9B);
    op(12'h162, 1'b1, 1'b0, 1'b0);
    core(8'hD9, 3'b100);
    rd_file(5'h02, 8'h99);
    op(12'h1C6, 1'b1, 1'b0, 1'b0);
    core(8'hF0, 3'b010);
    set_pins(8'h10);
    op(12'h1C6, 1'b1, 1'b0, 1'b0);
    core(8'h00, 3'b101);
    set_pins(8'hA3);
    op(12'h1C6, 1'b1, 1'b0, 1'b0);
    op(12'hE5F, 1'b1, 1'b0, 1'b0);
    core(8'h03, 3'b000);
    op(12'h142, 1'b1, 1'b0, 1'b0);
    core(8'h01, 3'b000);
  endtask

  // Port rewrite takes pin levels, then direction latches from the accumulator
  task automatic test_port();
    op(12'hE00, 1'b1, 1'b0, 1'b0);
    set_pins(8'hFF);
    op(12'h1C6, 1'b1, 1'b0, 1'b0);
    set_pins(8'h00);
    op(12'h1E6, 1'b1, 1'b0, 1'b0);
    cmp_byte(gpio_pin_out, 8'hFF);
    set_pins(8'h0F);
    op(12'h166, 1'b1, 1'b0, 1'b0);
    cmp_byte(gpio_pin_out, 8'h0F);
    rd_file(5'h06, 8'h0F);
    op(12'hE5A, 1'b1, 1'b0, 1'b0);
    op(12'h005, 1'b1, 1'b0, 1'b0);
    cmp_byte(gpio_pin_oe, 8'h00);
    op(12'h006, 1'b1, 1'b0, 1'b0);
    cmp_byte(gpio_pin_oe, 8'hA5);
    op(12'h007, 1'b1, 1'b0, 1'b0);
    cmp_byte(gpio_pin_oe, 8'hA5);
  endtask

  // Timer cell writes clear the prescaler only with write-back and assignment
  task automatic test_timer();
    @(posedge sys_clk);
    prescaler_on_timer <= 1'b1;
    op(12'h1C1, 1'b1, 1'b0, 1'b0);
    op(12'h1E1, 1'b1, 1'b0, 1'b1);
    op(12'h161, 1'b1, 1'b0, 1'b1);
    op(12'h1E2, 1'b1, 1'b0, 1'b0);
    @(posedge sys_clk);
    prescaler_on_timer <= 1'b0;
    op(12'h1E1, 1'b1, 1'b0, 1'b0);
  endtask

  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 12'h000;
    prescaler_on_timer = 1'b0;
    gpio_pin_in = 8'h00;
    file_rd_addr = 5'h00;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    test_idle();
    test_add_and();
    test_port();
    test_timer();
    wrap_up();
  end

  // Watchdog well beyond the roughly 140 cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    wrap_up();
  end
endmodule
